/* pkg/ldr_pkg.sv */
// Constants, field layout and carrier types of the deserializing receiver control block.
package ldr_pkg;

  // Link word layout: eight lanes, eight sample slots per link clock period.
  localparam int LANES         = 8;
  localparam int SLOTS         = 8;
  localparam int LANE_DATA_W   = 6;
  localparam int WORD_W        = 48;
  localparam int FIFO_DEPTH    = 8;
  localparam int BAL_FLAG_SLOT = 6;
  localparam int MODE_SLOT     = 7;
  localparam int MODE_LANE     = 0;

  // Training frame shapes seen through the unshifted window.
  localparam logic [7:0] TRAIN_ON_TIME = 8'h02;
  localparam logic [7:0] TRAIN_EARLY   = 8'h01;

  // Clock rate and timing figures.
  localparam int CLK_PERIOD_NS   = 100;
  localparam int CLK_FREQ_MHZ    = 10;
  localparam int LOSS_TIMEOUT_NS = 2000;
  localparam int LOSS_CYC_I      = (LOSS_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] LOSS_CYC = 8'(LOSS_CYC_I);
  localparam logic [2:0] LOCK_EDGES = 3'h4;
  localparam logic [7:0] MIN_PERIOD = 8'(SLOTS);

  // Automatic range changeover point, inside the 55 to 68 MHz band.
  localparam int RANGE_SHIFT_MHZ = 60;
  localparam int RANGE_SHIFT_I   = (CLK_FREQ_MHZ / RANGE_SHIFT_MHZ) < 1 ? 1 :
                                   (CLK_FREQ_MHZ / RANGE_SHIFT_MHZ);
  localparam logic [7:0] RANGE_SHIFT_CYC = 8'(RANGE_SHIFT_I);

  // Output strobe phase after a word is loaded.
  localparam logic [1:0] PH_IDLE = 2'h0;
  localparam logic [1:0] PH_LOAD = 2'h1;
  localparam logic [1:0] PH_HIGH = 2'h2;
  localparam logic [1:0] PH_LAST = 2'h3;

  typedef logic [WORD_W-1:0] ldr_word_t;
  typedef logic [LANES-1:0]  ldr_lane_t;

  // Status carried out of the receiver as one group.
  typedef struct packed {
    logic pll_locked;
    logic pll_high_range;
    logic dc_balanced;
    logic deskew_done;
    logic fifo_overrun;
  } ldr_status_s;

endpackage

/* design/ldr_receiver.sv */
// Deserializing receiver control: link sampling, lock, decode, buffering and output strobe.
`timescale 1ns/100ps

// Word buffer between the link decoder and the output stage.
module ldr_fifo #(
  parameter int W = 48,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_q [D];
  logic [AW:0]  wr_ptr_q;
  logic [AW:0]  rd_ptr_q;
  logic         full;
  logic         empty;

  // Full and empty from pointers that carry one wrap bit.
  assign full      = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign empty     = (wr_ptr_q == rd_ptr_q);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_q[rd_ptr_q[AW-1:0]];

  // Write side.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr_q <= '0;
    end else if (in_valid && !full) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data;
      wr_ptr_q                <= wr_ptr_q + 1'b1;
    end
  end

  // Read side.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_ptr_q <= '0;
    end else if (out_ready && !empty) begin
      rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end
endmodule

// Receiver control top level.
module ldr_receiver (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire ldr_pkg::ldr_lane_t   serial_data_in_pos,
  input  wire ldr_pkg::ldr_lane_t   serial_data_in_neg,
  input  wire logic                 link_clock_in_pos,
  input  wire logic                 link_clock_in_neg,
  input  wire logic                 pll_range_select,
  input  wire logic                 skew_correct_enable,
  input  wire logic                 power_down_n,
  input  wire logic                 out_ready,
  output ldr_pkg::ldr_word_t        parallel_data_out,
  output logic                      recovered_strobe_clock,
  output logic                      out_valid,
  output ldr_pkg::ldr_status_s      rx_status
);
  import ldr_pkg::*;

  localparam int PIN_W = 2 * LANES + 5;

  logic [PIN_W-1:0]       pin_s1_q;
  logic [PIN_W-1:0]       pin_s2_q;
  ldr_lane_t              dat_p;
  ldr_lane_t              dat_n;
  ldr_lane_t              lane_bit;
  logic                   lclk;
  logic                   lclk_q;
  logic                   rise;
  logic                   pd_n;
  logic                   range_sel;
  logic                   skew_en;
  logic                   run_b;
  logic [7:0]             per_cnt_q;
  logic [7:0]             per_last_q;
  logic [2:0]             edge_cnt_q;
  logic                   locked;
  logic                   link_lost;
  logic                   period_ok;
  logic                   high_range_q;
  logic [3:0]             slot_q;
  logic [3:0]             cur_slot;
  logic [LANES-1:0][7:0]  raw_q;
  ldr_lane_t              last7_q;
  ldr_lane_t              skew_q;
  logic [LANES-1:0][7:0]  win;
  logic [LANES-1:0][7:0]  plain_win;
  logic                   train_all;
  logic                   frame_ok;
  logic                   balanced_q;
  logic                   deskew_done_q;
  logic                   push;
  logic                   push_ready;
  ldr_word_t              push_word;
  logic                   pop_valid;
  logic                   pop;
  ldr_word_t              pop_word;
  logic [1:0]             phase_q;
  logic                   overrun_q;

  // Resolves one differential pair; equal legs mean nobody drives it, read as high.
  function automatic logic pair_level(input logic p, input logic n);
    pair_level = (p != n) ? p : 1'b1;
  endfunction

  // Decodes the lane windows into one word; balanced lanes undo the inversion flag.
  function automatic ldr_word_t decode_word(input logic [LANES-1:0][7:0] w, input logic balance_encode_select);
    ldr_word_t word;
    word = '0;
    for (int l = 0; l < LANES; l++) begin
      word[l*LANE_DATA_W +: LANE_DATA_W] = w[l][LANE_DATA_W-1:0]
                                         ^ {LANE_DATA_W{balance_encode_select & w[l][BAL_FLAG_SLOT]}};
    end
    return word;
  endfunction

  // Two-stage synchronisers on every pin but clk, rst_b and out_ready; open controls reset to low.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= {power_down_n, pll_range_select, skew_correct_enable,
                   link_clock_in_pos, link_clock_in_neg,
                   serial_data_in_pos, serial_data_in_neg};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Splits the synchronised pins and resolves each pair.
  assign pd_n      = pin_s2_q[PIN_W-1];
  assign range_sel = pin_s2_q[PIN_W-2];
  assign skew_en   = pin_s2_q[PIN_W-3];
  assign dat_p     = pin_s2_q[2*LANES-1:LANES];
  assign dat_n     = pin_s2_q[LANES-1:0];
  assign lclk      = pair_level(pin_s2_q[2*LANES+1], pin_s2_q[2*LANES]);
  assign run_b     = rst_b & pd_n;

  // Undriven pairs read as high so a dead cable gives no link clock edges.
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      lane_bit[l] = pair_level(dat_p[l], dat_n[l]);
    end
  end

  // Link clock edge finder.
  always_ff @(posedge clk) begin
    if (!run_b) begin
      lclk_q <= 1'b1;
    end else begin
      lclk_q <= lclk;
    end
  end
  assign rise = lclk && !lclk_q;

  // Period measurement between link clock rising edges.
  always_ff @(posedge clk) begin
    if (!run_b) begin
      per_cnt_q  <= 8'h00;
      per_last_q <= 8'h00;
    end else if (rise) begin
      per_cnt_q  <= 8'h01;
      per_last_q <= per_cnt_q;
    end else if (per_cnt_q != 8'hFF) begin
      per_cnt_q <= per_cnt_q + 8'h01;
    end
  end

  // A period counts toward lock when long enough and close to the last one.
  assign period_ok = (per_cnt_q >= MIN_PERIOD) &&
                     ((per_cnt_q >= per_last_q) ? (per_cnt_q - per_last_q) <= 8'h01
                                                : (per_last_q - per_cnt_q) <= 8'h01);
  assign link_lost = (per_cnt_q >= LOSS_CYC);
  assign locked    = (edge_cnt_q == LOCK_EDGES);

  // Lock: several steady periods in a row; lost on a stalled or unsteady clock.
  always_ff @(posedge clk) begin
    if (!run_b || link_lost) begin
      edge_cnt_q <= 3'h0;
    end else if (rise) begin
      if (!period_ok) begin
        edge_cnt_q <= 3'h0;
      end else if (!locked) begin
        edge_cnt_q <= edge_cnt_q + 3'h1;
      end
    end
  end

  // Range choice is frozen once locked, so it settles during the lock interval.
  always_ff @(posedge clk) begin
    if (!run_b || !range_sel) begin
      high_range_q <= 1'b0;
    end else if (rise && !locked) begin
      high_range_q <= (per_cnt_q < RANGE_SHIFT_CYC);
    end
  end

  // Slot counter: the sample taken on a rising edge is slot zero.
  assign cur_slot = rise ? 4'h0 : slot_q;
  always_ff @(posedge clk) begin
    if (!run_b) begin
      slot_q <= 4'(SLOTS);
    end else if (cur_slot < 4'(SLOTS)) begin
      slot_q <= cur_slot + 4'h1;
    end
  end

  // Stores each lane sample into its slot; a rising edge also saves the old slot seven.
  always_ff @(posedge clk) begin
    if (!run_b) begin
      raw_q   <= '1;
      last7_q <= '1;
    end else begin
      for (int l = 0; l < LANES; l++) begin
        if (cur_slot < 4'(SLOTS)) begin
          raw_q[l][cur_slot[2:0]] <= lane_bit[l];
        end
        if (rise) begin
          last7_q[l] <= raw_q[l][SLOTS-1];
        end
      end
    end
  end

  // Lane windows: early lanes are read one slot earlier, reaching into the prior frame.
  always_comb begin
    train_all = 1'b1;
    for (int l = 0; l < LANES; l++) begin
      plain_win[l] = raw_q[l];
      win[l]       = skew_q[l] ? {raw_q[l][SLOTS-2:0], last7_q[l]} : raw_q[l];
      if ((plain_win[l] != TRAIN_ON_TIME) && (plain_win[l] != TRAIN_EARLY)) begin
        train_all = 1'b0;
      end
    end
  end

  // A finished frame is judged on the edge that starts the next one.
  assign frame_ok = rise && locked && period_ok;

  // Deskew: training frames set the lane delays, only with balanced coding.
  always_ff @(posedge clk) begin
    if (!run_b || !skew_en) begin
      skew_q        <= '0;
      deskew_done_q <= 1'b0;
    end else if (frame_ok && balanced_q && train_all) begin
      for (int l = 0; l < LANES; l++) begin
        skew_q[l] <= (plain_win[l] == TRAIN_EARLY);
      end
      deskew_done_q <= 1'b1;
    end
  end

  // Coding detection from the marker slot of every good data frame, one that is pushed.
  always_ff @(posedge clk) begin
    if (!run_b) begin
      balanced_q <= 1'b0;
    end else if (push) begin
      balanced_q <= win[MODE_LANE][MODE_SLOT];
    end
  end

  // Each good frame that is not training yields one word.
  // Training frames carry no data, so they never reach the buffer, with deskew on or off.
  assign push      = frame_ok && !train_all;
  assign push_word = decode_word(win, win[MODE_LANE][MODE_SLOT]);

  // A word that finds the buffer full is dropped and flagged.
  always_ff @(posedge clk) begin
    if (!run_b) begin
      overrun_q <= 1'b0;
    end else if (push && !push_ready) begin
      overrun_q <= 1'b1;
    end
  end

  ldr_fifo #(
    .W (WORD_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (run_b),
    .in_valid  (push),
    .in_ready  (push_ready),
    .in_data   (push_word),
    .out_valid (pop_valid),
    .out_ready (pop),
    .out_data  (pop_word)
  );

  // Output stage pops only when idle and downstream is ready.
  assign pop = (phase_q == PH_IDLE) && out_ready && pd_n;

  // Strobe phase: load, then two high cycles, then one low cycle.
  always_ff @(posedge clk) begin
    if (!run_b) begin
      phase_q <= PH_IDLE;
    end else begin
      unique case (phase_q)
        PH_IDLE: begin
          if (pop && pop_valid) begin
            phase_q <= PH_LOAD;
          end
        end
        PH_LOAD: phase_q <= PH_HIGH;
        PH_HIGH: phase_q <= PH_LAST;
        PH_LAST: phase_q <= PH_IDLE;
      endcase
    end
  end

  // Output data holds its last word until a new one is popped or power-down clears it.
  always_ff @(posedge clk) begin
    if (!run_b) begin
      parallel_data_out <= '0;
      out_valid         <= 1'b0;
    end else if (pop && pop_valid) begin
      parallel_data_out <= pop_word;
      out_valid         <= 1'b1;
    end
  end

  // Strobe rises one cycle after the data changes and falls before the next change.
  always_ff @(posedge clk) begin
    if (!run_b) begin
      recovered_strobe_clock <= 1'b0;
    end else begin
      recovered_strobe_clock <= (phase_q == PH_LOAD) || (phase_q == PH_HIGH);
    end
  end

  // Status group.
  assign rx_status.pll_locked     = locked;
  assign rx_status.pll_high_range = high_range_q;
  assign rx_status.dc_balanced    = balanced_q;
  assign rx_status.deskew_done    = deskew_done_q;
  assign rx_status.fifo_overrun   = overrun_q;
endmodule

/* tb/ldr_receiver_sva.sv */
// Concurrent checks on the ports of the receiver control block.
`timescale 1ns/100ps
module ldr_receiver_sva (
  input wire logic                 clk,
  input wire logic                 rst_b,
  input wire logic                 power_down_n,
  input wire logic                 pll_range_select,
  input wire logic                 skew_correct_enable,
  input wire ldr_pkg::ldr_word_t   parallel_data_out,
  input wire logic                 recovered_strobe_clock,
  input wire logic                 out_valid,
  input wire ldr_pkg::ldr_status_s rx_status
);
  import ldr_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Power-down held long enough to pass the synchroniser and take effect.
  sequence pd_held;
    !power_down_n[*4];
  endsequence

  // Power-down released long enough that no clear can be in flight.
  sequence pd_free;
    power_down_n[*3];
  endsequence

  // The strobe stays up for its second cycle and then drops.
  sequence strobe_tail;
    recovered_strobe_clock ##1 !recovered_strobe_clock;
  endsequence

  AST_PD_CLEAR: assert property (pd_held |-> parallel_data_out == '0 && !out_valid)
    else $error("outputs not cleared in power-down");
  AST_STROBE_HIGH: assert property ($rose(recovered_strobe_clock) |=> strobe_tail)
    else $error("strobe high time wrong");
  AST_STROBE_LOW: assert property ($fell(recovered_strobe_clock) |-> !recovered_strobe_clock[*2])
    else $error("strobe low time too short");
  AST_DATA_STABLE: assert property (recovered_strobe_clock |-> $stable(parallel_data_out))
    else $error("data moved while strobe high");
  AST_DATA_TO_STROBE: assert property (
    $changed(parallel_data_out) && parallel_data_out != '0 |=> $rose(recovered_strobe_clock))
    else $error("new data without strobe");
  AST_VALID_AT_STROBE: assert property ($rose(recovered_strobe_clock) |-> out_valid)
    else $error("strobe without valid");
  AST_VALID_HOLDS: assert property (pd_free ##0 out_valid |=> out_valid)
    else $error("valid dropped without power-down");
  AST_RANGE_LOW: assert property (!pll_range_select[*4] |-> !rx_status.pll_high_range)
    else $error("high range with range select low");
  AST_RANGE_SHIFT: assert property (!rx_status.pll_high_range)
    else $error("high range below changeover rate");
  AST_DESKEW_OFF: assert property (!skew_correct_enable[*4] |-> !rx_status.deskew_done)
    else $error("deskew done while disabled");
endmodule

bind ldr_receiver ldr_receiver_sva ldr_receiver_sva_inst (
  .clk(clk), .rst_b(rst_b), .power_down_n(power_down_n), .pll_range_select(pll_range_select),
  .skew_correct_enable(skew_correct_enable), .parallel_data_out(parallel_data_out),
  .recovered_strobe_clock(recovered_strobe_clock), .out_valid(out_valid),
  .rx_status(rx_status));

/* tb/ldr_ser_model.sv */
// Behavioural serializer that drives the lane pairs and the forwarded link clock.
`timescale 1ns/100ps
module ldr_ser_model (
  input  wire logic              run,
  input  wire logic              train,
  input  wire logic              balance_encode_select,
  input  wire ldr_pkg::ldr_word_t word,
  output ldr_pkg::ldr_lane_t     lane_p,
  output ldr_pkg::ldr_lane_t     lane_n,
  output logic                   lclk_p,
  output logic                   lclk_n,
  output int                     frame_cnt
);
  import ldr_pkg::*;
  ldr_word_t  sent_q[$];
  logic [7:0] win[LANES];
  logic [5:0] d6;
  logic       flip;

  // One eight-slot frame per 800 ns; an unplugged cable leaves both legs equal.
  initial begin
    frame_cnt = 0;
    {lane_p, lane_n, lclk_p, lclk_n} = '0;
    #37;
    forever begin
      if (!run) begin
        {lane_p, lane_n, lclk_p, lclk_n} = '0;
        #100;
      end else begin
        for (int l = 0; l < LANES; l++) begin
          d6 = word[6*l +: 6];
          flip = balance_encode_select && ($countones(d6) > 3);
          win[l] = {(l == 0) && balance_encode_select, flip, d6 ^ {6{flip}}};
          if (train) win[l] = TRAIN_ON_TIME;
        end
        if (!train) sent_q.push_back(word);
        frame_cnt++;
        for (int k = 0; k < SLOTS; k++) begin
          for (int l = 0; l < LANES; l++) lane_p[l] = win[l][k];
          lane_n = ~lane_p;
          lclk_p = (k < 4);
          lclk_n = !lclk_p;
          #100;
        end
      end
    end
  end
endmodule

/* tb/ldr_receiver_tb.sv */
// Self-checking bench for the receiver control block.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module ldr_receiver_tb;
  import ldr_pkg::*;
  logic        clk, rst_b, pll_range_select, skew_correct_enable, power_down_n, out_ready;
  logic        run, train, balance_encode_select, lclk_p, lclk_n, strobe, strobe_d, ovalid;
  logic [1:0]  rdy_mode;
  ldr_lane_t   lane_p, lane_n;
  ldr_word_t   word, pdo, last_w, exp_w;
  ldr_status_s st;
  int          n_fail, cmp_count, fc;

  ldr_receiver ldr_receiver_inst (.clk(clk), .rst_b(rst_b), .serial_data_in_pos(lane_p),
    .serial_data_in_neg(lane_n), .link_clock_in_pos(lclk_p), .link_clock_in_neg(lclk_n),
    .pll_range_select(pll_range_select), .skew_correct_enable(skew_correct_enable),
    .power_down_n(power_down_n), .out_ready(out_ready), .parallel_data_out(pdo),
    .recovered_strobe_clock(strobe), .out_valid(ovalid), .rx_status(st));
  ldr_ser_model ldr_ser_model_inst (.run(run), .train(train), .balance_encode_select(balance_encode_select), .word(word),
    .lane_p(lane_p), .lane_n(lane_n), .lclk_p(lclk_p), .lclk_n(lclk_n), .frame_cnt(fc));

  // System clock of 100 ns.
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  // Downstream ready: held low, held high, or random.
  always @(posedge clk) out_ready <= rdy_mode[1] ? ($urandom_range(3) != 0) : rdy_mode[0];

  // Oldest word sent, or unknown when nothing is owed.
  function automatic ldr_word_t next_exp();
    if (ldr_ser_model_inst.sent_q.size() > 0) return ldr_ser_model_inst.sent_q.pop_front();
    return 'x;
  endfunction

  // Each strobe rise must present the next word in the order sent.
  always @(negedge clk) begin
    strobe_d <= strobe;
    if (strobe && !strobe_d) begin
      exp_w = next_exp();
      last_w = pdo;
      `CHK("word", exp_w, pdo)
    end
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Sends n frames; b picks plain, balanced or random coding.
  task automatic frames(input int n, input logic t, input logic [1:0] b);
    int c;
    for (int i = 0; i < n; i++) begin
      train = t;
      word = ldr_word_t'({$urandom(), $urandom()}) | 48'h1;
      balance_encode_select = b[1] ? 1'($urandom_range(1)) : b[0];
      c = fc;
      for (int j = 0; j < 20 && fc == c; j++) @(posedge clk);
      if (fc == c) begin
        n_fail++;
        complete_run();
      end
    end
  endtask

  // Waits until every word sent has come out.
  task automatic drain();
    for (int i = 0; i < 900 && ldr_ser_model_inst.sent_q.size() > 0; i++) @(posedge clk);
    @(negedge clk);
    if (ldr_ser_model_inst.sent_q.size() > 0) begin
      n_fail++;
      complete_run();
    end
  endtask

  // Main sequence.
  initial begin
    {rst_b, pll_range_select, skew_correct_enable, run, train, balance_encode_select} = '0;
    {power_down_n, strobe_d} = 2'h2;
    rdy_mode = 2'h1;
    word = '0;
    n_fail = 0;
    cmp_count = 0;
    void'($urandom(26425));
    repeat (12) @(posedge clk);
    rst_b <= 1'h1;
    repeat (3) @(posedge clk);
    run = 1'h1;
    frames(8, 1, 0);
    @(negedge clk);
    `CHK("locked", 1'h1, st.pll_locked)
    rdy_mode = 2'h2;
    frames(24, 0, 2);
    frames(1, 1, 0);
    rdy_mode = 2'h1;
    drain();
    @(posedge clk) skew_correct_enable <= 1'h1;
    frames(1, 0, 1);
    frames(4, 1, 0);
    drain();
    `CHK("deskew done", 1'h1, st.deskew_done)
    `CHK("balanced", 1'h1, st.dc_balanced)
    @(posedge clk) skew_correct_enable <= 1'h0;
    repeat (4) @(negedge clk);
    `CHK("deskew off", 1'h0, st.deskew_done)
    rdy_mode = 2'h0;
    frames(10, 0, 2);
    frames(2, 1, 0);
    @(negedge clk);
    `CHK("overrun", 1'h1, st.fifo_overrun)
    repeat (2) void'(ldr_ser_model_inst.sent_q.pop_back());
    rdy_mode = 2'h1;
    drain();
    run = 1'h0;
    repeat (30) @(negedge clk);
    `CHK("lock lost", 1'h0, st.pll_locked)
    `CHK("held word", last_w, pdo)
    run = 1'h1;
    frames(8, 1, 0);
    @(posedge clk) power_down_n <= 1'h0;
    repeat (4) @(negedge clk);
    `CHK("pd data", 48'h0, pdo)
    `CHK("pd valid", 1'h0, ovalid)
    `CHK("pd overrun", 1'h0, st.fifo_overrun)
    @(posedge clk) begin
      power_down_n <= 1'h1;
      pll_range_select <= 1'($urandom_range(1));
    end
    frames(8, 1, 0);
    frames(6, 0, 2);
    frames(1, 0, 0);
    frames(1, 1, 0);
    drain();
    `CHK("plain", 1'h0, st.dc_balanced)
    `CHK("low range", 1'h0, st.pll_high_range)
    complete_run();
  end
endmodule
